// ---- pc_fetch_pipeline.sv ----
// Overview of operation
// - 21-bit byte program counter, low byte accessible
// - middle bits written only through middle latch
// - upper bits written only through upper latch
// - bit zero stays zero; fetch steps two
// - calls, gotos, branches load target directly
// - low byte write loads counter from both latches
// - low byte read copies counter into latches
// - clock divided into four phases per cycle
// - counter steps in phase one; ir loads phase four
// - operand read phase two, write phase four
// - fetch overlaps execute; jumps take two cycles
// - counter change flushes fetched word as nop
// - words little endian at even addresses
// - absolute target is a word address
// - relative offset counts words, doubled in bytes
// - second words: ones on top, 12 data bits
// - lone second word executes as nop
// - working register added to low byte jumps
// - table pointer addresses bytes, latch holds byte
// - reset starts at address zero
// - return stack of 31 levels for calls
`timescale 1ns/1ps
`include "pc_fetch_cfg.svh"

module pc_fetch_pipeline (
    input wire logic clock,
    input wire logic rstn,
    output logic [20:0] prog_addr,
    output logic prog_read,
    input wire logic [15:0] prog_data,
    output logic [15:0] ir,
    output logic ir_live,
    output logic dmem_read_strobe,
    output logic dmem_write_strobe,
    input wire logic skip_next,
    input wire logic low_byte_read,
    input wire logic low_byte_write,
    input wire logic [7:0] low_byte_wdata,
    input wire logic low_byte_add,
    input wire logic [7:0] working_register,
    output logic [7:0] pc_low_byte,
    input wire logic middle_latch_write,
    input wire logic upper_latch_write,
    input wire logic [7:0] latch_wdata,
    output logic [7:0] pc_middle_latch,
    output logic [4:0] pc_upper_latch,
    input wire logic table_pointer_write,
    input wire logic [20:0] table_pointer_wdata,
    output logic [20:0] table_byte_pointer,
    output logic table_read_strobe,
    input wire logic [7:0] table_read_byte,
    output logic [7:0] table_data_latch,
    output logic [4:0] stack_depth,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four
);

    pc_fetch_pkg::core_state_type state;
    pc_fetch_pkg::core_state_type next_state;

    // ==========================================================
    // phase generation
    phase_divider phases (
        .clock(clock),
        .rstn(rstn),
        .phase_one(phase_one),
        .phase_two(phase_two),
        .phase_three(phase_three),
        .phase_four(phase_four)
    );

    // ==========================================================
    // decode of the word held in the instruction register
    logic is_second_word;
    logic executing;
    logic is_goto;
    logic is_call;
    logic is_branch;
    logic is_relative_call;
    logic is_push;
    logic is_pop;
    logic is_return;
    logic is_table_read;
    logic do_low_read;
    logic do_low_write;
    logic do_low_add;
    logic redirect;
    logic [1:0] table_mode;
    logic [19:0] absolute_word;
    logic [20:0] relative_target;
    logic [7:0] added_low_byte;
    logic [20:0] stack_top;

    // a lone second word carries the all-ones mark and must do nothing
    assign is_second_word = (state.ir[15:12] == `SECOND_WORD_MARK);
    // flushed words never reach any decoded action
    assign executing = state.ir_live && !is_second_word;

    assign is_goto = executing && (state.ir[15:8] == `OP_GOTO);
    assign is_call = executing && (state.ir[15:9] == `OP_CALL);
    assign is_branch = executing && (state.ir[15:11] == `OP_BRANCH);
    assign is_relative_call = executing && (state.ir[15:11] == `OP_RELATIVE_CALL);
    assign is_push = executing && (state.ir == `OP_PUSH);
    assign is_pop = executing && (state.ir == `OP_POP);
    assign is_return = executing && ((state.ir[15:1] == `OP_RETURN)
        || (state.ir[15:1] == `OP_RETURN_INT)
        || (state.ir[15:8] == `OP_RETURN_LITERAL));
    assign is_table_read = executing && (state.ir[15:2] == `OP_TABLE_READ);
    assign table_mode = state.ir[1:0];

    // strobes from the execute side only count for live words
    assign do_low_read = executing && low_byte_read;
    assign do_low_write = executing && low_byte_write;
    assign do_low_add = executing && low_byte_add;

    // ==========================================================
    // target arithmetic
    // first word holds the low 8 target bits, second word the upper 12
    assign absolute_word = {prog_data[11:0], state.ir[7:0]};

    // the fetch address already points past the branch, as seen by software
    assign relative_target = state.fetch_addr
        + {{9{state.ir[10]}}, state.ir[10:0], 1'b0};

    // no carry into the middle byte: tables must not straddle 256 bytes
    assign added_low_byte = state.fetch_addr[7:0] + working_register;

    assign stack_top = (state.stack_pointer == `STACK_EMPTY) ?
        `PC_RESET_VECTOR : state.stack[state.stack_pointer];

    // any change of flow at phase four costs the word in flight
    assign redirect = phase_four && (is_goto || is_call || is_branch
        || is_relative_call || is_return || do_low_write || do_low_add);

    // ==========================================================
    // next state
    always_comb begin
        next_state = state;

        // fetch: address captured and counter stepped in phase one
        if (phase_one) begin
            next_state.fetch_addr = state.pc;
            next_state.pc = state.pc + `PC_STEP;
        end

        // low byte read copies the upper parts into the latches
        if (phase_two && (do_low_read || do_low_add)) begin
            next_state.pc_middle_latch =
                state.fetch_addr[`PC_MIDDLE_MSB:`PC_MIDDLE_LSB];
            next_state.pc_upper_latch =
                state.fetch_addr[`PC_UPPER_MSB:`PC_UPPER_LSB];
        end

        // pre-increment moves the pointer before the byte is read in phase three
        if (phase_two && is_table_read && (table_mode == `TABLE_MODE_PRE_INC)) begin
            next_state.table_byte_pointer = state.table_byte_pointer + 21'h000001;
        end

        if (phase_four) begin
            // latch writes only hold a value; the counter is untouched here
            if (executing && middle_latch_write) begin
                next_state.pc_middle_latch = latch_wdata;
            end
            if (executing && upper_latch_write) begin
                next_state.pc_upper_latch = latch_wdata[4:0];
            end

            // table transfer moves one byte per instruction
            if (executing && table_pointer_write) begin
                next_state.table_byte_pointer = table_pointer_wdata;
            end
            if (is_table_read) begin
                next_state.table_data_latch = table_read_byte;
                if (table_mode == `TABLE_MODE_POST_INC) begin
                    next_state.table_byte_pointer = state.table_byte_pointer + 21'h000001;
                end
                if (table_mode == `TABLE_MODE_POST_DEC) begin
                    next_state.table_byte_pointer = state.table_byte_pointer - 21'h000001;
                end
            end

            // instruction register loads the fetched word
            next_state.ir = prog_data;
            next_state.ir_live = !(redirect || (executing && skip_next));

            // counter loads, latches bypassed for direct targets
            if (is_goto || is_call) begin
                next_state.pc = {absolute_word, 1'b0};
            end
            if (is_branch || is_relative_call) begin
                next_state.pc = {relative_target[20:1], 1'b0};
            end
            if (do_low_write) begin
                next_state.pc = {state.pc_upper_latch, state.pc_middle_latch,
                    low_byte_wdata[7:1], 1'b0};
            end
            if (do_low_add) begin
                // the read half has already refreshed the latches
                next_state.pc = {state.pc_upper_latch, state.pc_middle_latch,
                    added_low_byte[7:1], 1'b0};
            end

            // return stack: overflow overwrites the top, underflow yields zero
            if (is_call) begin
                if (state.stack_pointer != `STACK_TOP_LEVEL) begin
                    next_state.stack_pointer = state.stack_pointer + 5'h01;
                end
                next_state.stack[next_state.stack_pointer] = state.pc;
            end
            if (is_relative_call || is_push) begin
                if (state.stack_pointer != `STACK_TOP_LEVEL) begin
                    next_state.stack_pointer = state.stack_pointer + 5'h01;
                end
                next_state.stack[next_state.stack_pointer] = state.fetch_addr;
            end
            if (is_return) begin
                next_state.pc = stack_top;
                if (state.stack_pointer != `STACK_EMPTY) begin
                    next_state.stack_pointer = state.stack_pointer - 5'h01;
                end
            end
            if (is_pop && (state.stack_pointer != `STACK_EMPTY)) begin
                next_state.stack_pointer = state.stack_pointer - 5'h01;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state.pc <= `PC_RESET_VECTOR;
            state.fetch_addr <= `PC_RESET_VECTOR;
            state.pc_middle_latch <= 8'h00;
            state.pc_upper_latch <= 5'h00;
            state.ir <= 16'h0000;
            state.ir_live <= 1'b0;
            state.table_byte_pointer <= 21'h000000;
            state.table_data_latch <= 8'h00;
            state.stack_pointer <= `STACK_EMPTY;
            state.stack <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign prog_addr = state.fetch_addr;
    assign prog_read = phase_two;
    assign ir = state.ir;
    assign ir_live = state.ir_live;

    // operand read in phase two, destination write in phase four
    assign dmem_read_strobe = phase_two && executing;
    assign dmem_write_strobe = phase_four && executing;

    // software sees the address of the word being fetched, bit zero clear
    assign pc_low_byte = {state.fetch_addr[7:1], 1'b0};
    assign pc_middle_latch = state.pc_middle_latch;
    assign pc_upper_latch = state.pc_upper_latch;

    assign table_byte_pointer = state.table_byte_pointer;
    assign table_read_strobe = phase_three && is_table_read;
    assign table_data_latch = state.table_data_latch;
    assign stack_depth = state.stack_pointer;

endmodule : pc_fetch_pipeline

// ---- pc_fetch_cfg.svh ----
`ifndef PC_FETCH_CFG_SVH
`define PC_FETCH_CFG_SVH

// ==============================================================
// program counter layout
`define PC_WIDTH 21
`define PC_RESET_VECTOR 21'h000000
`define PC_STEP 21'h000002
`define PC_MIDDLE_MSB 15
`define PC_MIDDLE_LSB 8
`define PC_UPPER_MSB 20
`define PC_UPPER_LSB 16

// ==============================================================
// instruction word fields
`define SECOND_WORD_MARK 4'hF
`define OP_GOTO 8'hEF
`define OP_CALL 7'h76
`define OP_BRANCH 5'h1A
`define OP_RELATIVE_CALL 5'h1B
`define OP_PUSH 16'h0005
`define OP_POP 16'h0006
`define OP_RETURN 15'h0009
`define OP_RETURN_INT 15'h0008
`define OP_RETURN_LITERAL 8'h0C
`define OP_TABLE_READ 14'h0002

// ==============================================================
// table pointer modes
`define TABLE_MODE_HOLD 2'h0
`define TABLE_MODE_POST_INC 2'h1
`define TABLE_MODE_POST_DEC 2'h2
`define TABLE_MODE_PRE_INC 2'h3

// ==============================================================
// return stack
`define STACK_TOP_LEVEL 5'h1F
`define STACK_EMPTY 5'h00

`endif

// ---- pc_fetch_pkg.sv ----
package pc_fetch_pkg;

    // ==========================================================
    // quadrature phase sequence
    typedef enum logic [1:0] {
        PHASE_ONE = 2'b00,
        PHASE_TWO = 2'b01,
        PHASE_THREE = 2'b10,
        PHASE_FOUR = 2'b11
    } phase_type;

    typedef struct packed {
        phase_type phase;
    } phase_state_type;

    // ==========================================================
    // core pipeline state
    typedef struct packed {
        logic [20:0] pc;
        logic [20:0] fetch_addr;
        logic [7:0] pc_middle_latch;
        logic [4:0] pc_upper_latch;
        logic [15:0] ir;
        logic ir_live;
        logic [20:0] table_byte_pointer;
        logic [7:0] table_data_latch;
        logic [4:0] stack_pointer;
        logic [31:1][20:0] stack;
    } core_state_type;

endpackage : pc_fetch_pkg

// ---- phase_divider.sv ----
`timescale 1ns/1ps

module phase_divider (
    input wire logic clock,
    input wire logic rstn,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four
);

    pc_fetch_pkg::phase_state_type state;
    pc_fetch_pkg::phase_state_type next_state;

    // ==========================================================
    // four non-overlapping phases, one clock each
    always_comb begin
        next_state = state;
        unique case (state.phase)
            pc_fetch_pkg::PHASE_ONE: next_state.phase = pc_fetch_pkg::PHASE_TWO;
            pc_fetch_pkg::PHASE_TWO: next_state.phase = pc_fetch_pkg::PHASE_THREE;
            pc_fetch_pkg::PHASE_THREE: next_state.phase = pc_fetch_pkg::PHASE_FOUR;
            pc_fetch_pkg::PHASE_FOUR: next_state.phase = pc_fetch_pkg::PHASE_ONE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state.phase <= pc_fetch_pkg::PHASE_ONE;
        end else begin
            state <= next_state;
        end
    end

    assign phase_one = (state.phase == pc_fetch_pkg::PHASE_ONE);
    assign phase_two = (state.phase == pc_fetch_pkg::PHASE_TWO);
    assign phase_three = (state.phase == pc_fetch_pkg::PHASE_THREE);
    assign phase_four = (state.phase == pc_fetch_pkg::PHASE_FOUR);

endmodule : phase_divider

// ---- prog_mem_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// program memory: byte array, answers promptly or after lat clocks
module prog_mem_model (
    input wire logic clock,
    input wire logic [20:0] prog_addr,
    input wire logic [20:0] table_byte_pointer,
    input wire logic table_read_strobe,
    output logic [15:0] prog_data,
    output logic [7:0] table_read_byte
);
    logic [7:0] mem [int];
    int lat = 0;
    int age = 0;
    logic [20:0] seen = 21'h000000;
    logic [15:0] junk = 16'h5A5A;

    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction : rd

    // junk flips every clock so a stale word never looks like a valid one
    always @(posedge clock) begin
        age <= (prog_addr != seen) ? 1 : age + 1;
        seen <= prog_addr;
        junk <= ~junk;
        if (table_read_strobe) begin
            table_read_byte <= rd(table_byte_pointer);
        end
    end

    // low byte of a word sits at the even address
    assign prog_data = (lat == 0 || (prog_addr == seen && age >= lat)) ?
        {rd(prog_addr | 21'h1), rd(prog_addr & ~21'h1)} : junk;
endmodule : prog_mem_model

// ---- pc_fetch_chk.sv ----
`timescale 1ns/1ps
// ==========================================================
// fetch pipeline checker
module pc_fetch_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [20:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic [15:0] ir,
    input wire logic ir_live,
    input wire logic dmem_read_strobe,
    input wire logic dmem_write_strobe,
    input wire logic low_byte_read,
    input wire logic low_byte_write,
    input wire logic [7:0] low_byte_wdata,
    input wire logic [7:0] pc_middle_latch,
    input wire logic [4:0] pc_upper_latch,
    input wire logic [4:0] stack_depth,
    input wire logic phase_one,
    input wire logic phase_two,
    input wire logic phase_three,
    input wire logic phase_four
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    logic live;
    // second words never act, so they count as not live
    assign live = ir_live && ir[15:12] != 4'hF;

    property p_phase_cycle;
        phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) else $error("phase order");
    property p_addr_hold;
        !phase_one |=> $stable(prog_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
    property p_second_step;
        phase_four && ir[15:12] == 4'hF |-> ##2 prog_addr == $past(prog_addr, 2) + 21'h2;
    endproperty
    a_second_step: assert property (p_second_step) else $error("no step of two");
    property p_ir_load;
        phase_four |=> ir == $past(prog_data);
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("ir not loaded");
    property p_rd_strobe;
        dmem_read_strobe == (phase_two && live);
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe");
    property p_wr_strobe;
        dmem_write_strobe == (phase_four && live);
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe");
    property p_low_write;
        phase_four && live && low_byte_write |=> !ir_live ##1 prog_addr == {$past(pc_upper_latch, 2),
            $past(pc_middle_latch, 2), $past(low_byte_wdata, 2) & 8'hFE};
    endproperty
    a_low_write: assert property (p_low_write) else $error("low byte write jump");
    property p_read_copy;
        phase_two && live && low_byte_read |-> ##[1:2] (pc_middle_latch == prog_addr[15:8]
            && pc_upper_latch == prog_addr[20:16]);
    endproperty
    a_read_copy: assert property (p_read_copy) else $error("latch copy");
    property p_reset;
        disable iff (1'b0) !rstn |=> prog_addr == 21'h000000 && !ir_live && stack_depth == 5'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");

    c_flush: cover property (phase_four && live && low_byte_write);
    c_lone_second: cover property (phase_four && ir_live && ir[15:12] == 4'hF);
    c_stack: cover property (stack_depth == 5'h01);
endmodule : pc_fetch_chk

bind pc_fetch_pipeline pc_fetch_chk chk (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic prog_read, ir_live, dmem_read_strobe, dmem_write_strobe, table_read_strobe;
    logic phase_one, phase_two, phase_three, phase_four, lv;
    logic [20:0] prog_addr, table_byte_pointer;
    logic [15:0] prog_data, ir;
    logic [7:0] pc_low_byte, pc_middle_latch, table_read_byte, table_data_latch;
    logic [4:0] pc_upper_latch, stack_depth;
    logic skip_next = 1'b0, low_byte_read = 1'b0, low_byte_write = 1'b0, low_byte_add = 1'b0;
    logic middle_latch_write = 1'b0, upper_latch_write = 1'b0, table_pointer_write = 1'b0;
    logic [7:0] low_byte_wdata = 8'h00, working_register = 8'h00, latch_wdata = 8'h00, ml = 8'h80;
    logic [20:0] table_pointer_wdata = 21'h000000;
    logic [4:0] ul = 5'h00;
    logic [20:0] fetched [$];
    logic [20:0] expected [$];
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    pc_fetch_pipeline dut (.*);
    prog_mem_model pm (.*);

    always #2.5 clock = ~clock;

    // ==========================================================
    // execute-side stimulus decoded from the live instruction
    always @(negedge clock) begin
        lv = (ir_live === 1'b1);
        if (prog_read === 1'b1) begin
            fetched.push_back(prog_addr);
        end
        low_byte_write = lv && ir == 16'h0E01;
        middle_latch_write = lv && (ir == 16'h0E02 || ir == 16'h0E09);
        upper_latch_write = lv && ir == 16'h0E03;
        latch_wdata = (ir == 16'h0E03) ? {3'h0, ul} : ((ir == 16'h0E09) ? ~ml : ml);
        low_byte_read = lv && (ir == 16'h0E04 || ir == 16'h0E05);
        low_byte_add = lv && ir == 16'h0E05;
        skip_next = lv && ir == 16'h0E06;
        table_pointer_write = lv && ir == 16'h0E07;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end

    // ==========================================================
    // compares and verdict
    task automatic check_addr(input logic [20:0] got, input logic [20:0] want);
        num_checks++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask : check_addr

    task automatic check_byte(input logic [7:0] got, input logic [7:0] want);
        num_checks++;
        if (got !== want) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask : check_byte

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // one program: goto, branch, latch jump, add jump, skip, call, table read
    task automatic run_round(input int lat);
        logic [20:0] t;
        logic [20:0] u;
        logic [20:0] at [18];
        logic [15:0] wd [18];
        logic [7:0] tp_byte;
        pm.mem.delete();
        pm.lat = lat;
        ml = {1'b1, 7'($urandom)};
        ul = 5'($urandom);
        low_byte_wdata = 8'($urandom) & 8'h7F;
        working_register = 8'($urandom) & 8'h3E;
        table_pointer_wdata = 21'($urandom % 72);
        t = {ul, ml, low_byte_wdata & 8'hFE};
        u = {ul, ml, t[7:0] + 8'h06 + working_register};
        at = '{21'h0, 21'h2, 21'h4, 21'h6, 21'h40, 21'h42, 21'h44, t, t + 21'h2, t + 21'h4,
            u, u + 21'h2, u + 21'h4, u + 21'h6, 21'h80, 21'h82, 21'h84, u + 21'h8};
        wd = '{16'h0E00, 16'hEF03, 16'hF000, 16'hD01C, 16'h0E02, 16'h0E03, 16'h0E01, 16'h0E09,
            16'h0E04, 16'h0E05, 16'h0E06, 16'h0E01, 16'hEC40, 16'hF000, 16'h0E07, 16'h0008,
            16'h0012, 16'hF123};
        foreach (at[k]) begin
            pm.mem[int'(at[k])] = wd[k][7:0];
            pm.mem[int'(at[k]) + 1] = wd[k][15:8];
        end
        tp_byte = pm.mem.exists(int'(table_pointer_wdata)) ? pm.mem[int'(table_pointer_wdata)] : 8'h00;
        expected = {21'h0, 21'h2, 21'h4, 21'h6, 21'h8, 21'h40, 21'h42, 21'h44, 21'h46, t,
            t + 21'h2, t + 21'h4, t + 21'h6, u, u + 21'h2, u + 21'h4, u + 21'h6, 21'h80,
            21'h82, 21'h84, 21'h86, u + 21'h8, u + 21'hA, u + 21'hC};
        rstn = 1'b0;
        repeat (6) @(negedge clock);
        fetched.delete();
        rstn = 1'b1;
        repeat (100) @(negedge clock);
        foreach (expected[k]) begin
            check_addr(fetched[k], expected[k]);
        end
        check_byte(pc_middle_latch, ml);
        check_byte({3'h0, pc_upper_latch}, {3'h0, ul});
        check_addr(table_byte_pointer, table_pointer_wdata);
        check_byte(table_data_latch, tp_byte);
        check_byte({3'h0, stack_depth}, 8'h00);
        // the run ends on the nop words that follow the lone second word
        check_byte(pc_low_byte, 8'(u + 21'h00000E));
        $display("round with memory latency %0d done", lat);
    endtask : run_round

    initial begin
        void'($urandom(1));
        @(negedge clock);
        for (int r = 0; r < 3; r++) begin
            run_round(r);
        end
        print_verdict();
    end
endmodule : tb_top
